// File: hw/pmbus_core_map.svh
`ifndef PMBUS_CORE_MAP_SVH
`define PMBUS_CORE_MAP_SVH
`define CMD_CHANNEL_SELECT 8'h00
`define CMD_OUTPUT_ON_OFF 8'h01
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_WRITE_GUARD 8'h10
`define CMD_STORE_ALL 8'h15
`define CMD_RESTORE_ALL 8'h16
`define CMD_VOLTAGE_FORMAT 8'h20
`define CMD_VOLTAGE_SETPOINT 8'h21
`define CMD_SCALE_LOOP 8'h29
`define CMD_STATUS_BYTE 8'h78
`define CMD_STATUS_CML 8'h7E
`define CMD_CRC_FLAG 8'hD5
`define PAGE_BOTH 8'hFF
`define RST_CHANNEL_SELECT 8'h00
`define RST_OUTPUT_ON_OFF 8'h00
`define RST_WRITE_GUARD 8'h00
`define RST_SETPOINT 16'h1400
`define RST_SCALE_LOOP 16'hB052
`define VOLTAGE_FORMAT_VAL 8'h16
`define GUARD_ALL 8'h80
`define GUARD_CTRL 8'h40
`define GUARD_VOUT 8'h20
`define ON_BIT 7
`define NV_STEPS 3'h4
`define NV_CRC_BLANK 8'hFF
`define CML_BAD_WRITE 8'h02
`define CML_CRC_BIT 1
`define OFF_BIT 6
`define CML_SUMMARY_BIT 1
`endif

// File: hw/pmbus_core_pkg.sv
package pmbus_core_pkg;
	typedef enum logic [3:0] {
		NV_IDLE = 4'b0001,
		NV_STORE = 4'b0010,
		NV_RESTORE = 4'b0100,
		NV_DONE = 4'b1000
	} nv_state_t;
endpackage

// File: hw/pmbus_dual_channel_command_core.sv
`timescale 1ns/1ps
`include "pmbus_core_map.svh"
// Notes on behaviour
// - linear sixteen: unsigned mantissa, 5-bit exponent
// - linear eleven: 11-bit mantissa, 5-bit exponent
// - any exponent value accepted, stored verbatim
// - page bit0 picks channel, reset channel zero
// - page 0xFF writes both channels alike
// - single-copy registers reachable from any page
// - 0x80 turns on, 0x00/0x40 off
// - on bit 7; enable pin overrides
// - clear faults wipes status, drops alert
// - clear faults never restarts latched outputs
// - persisting fault sets again at once
// - write guard levels gate writes
// - reads served at every guard level
// - store copies operating regs to nonvolatile
// - writes rejected, reads served while busy
// - store programs crc byte
// - outputs off during store or restore
// - store only once, only when unprogrammed
// - restore loads nonvolatile into operating regs
// - restore loads only when crc matches
// - voltage format reads 0x16 fixed
// - set-point word resets to 5120
module pmbus_dual_channel_command_core
	import pmbus_core_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic cmdValid,
	input wire logic cmdWrite,
	input wire logic [7:0] cmdCode,
	input wire logic [15:0] cmdData,
	output logic [15:0] rdData,
	input wire logic factoryBlank,
	input wire logic [1:0] enablePin,
	input wire logic [1:0] faultPresent,
	input wire logic [1:0] latchedOff,
	output logic [1:0] channelEnable,
	output logic alert_line,
	output logic nvBusy
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0] channelSelect;
	logic [7:0] writeGuardLevel;
	logic [7:0] outputOnOff [2];
	logic [15:0] voltageSetpoint [2];
	logic [15:0] scaleLoop [2];
	logic [7:0] statusByte [2];
	logic [7:0] statusCml;
	logic crcFlag;
	logic storeUsed;
	logic [7:0] nvOnOff [2];
	logic [15:0] nvSetpoint [2];
	logic [15:0] nvScale [2];
	logic [7:0] nvCrc;
	nv_state_t nvState;
	logic [2:0] nvCount;
	logic [1:0] enSync0, enSync1, enSync2;
	logic [1:0] enPin;
	logic [1:0] faultSync0, faultSync1, faultSync2;
	logic [1:0] faultNow;
	logic chan;
	logic wrAny, wrOk, clearReq;
	logic [1:0] wrChan;

	// crc-8 over the stored words, byte at a time, polynomial 0x07
	function automatic logic [7:0] crc_byte(input logic [7:0] c,
			input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
		end
		return r;
	endfunction

	function automatic logic [7:0] crc_image(input logic [7:0] a0,
			input logic [7:0] a1, input logic [15:0] s0,
			input logic [15:0] s1, input logic [15:0] k0,
			input logic [15:0] k1);
		logic [7:0] c;
		c = crc_byte(8'h00, a0);
		c = crc_byte(c, a1);
		c = crc_byte(c, s0[7:0]);
		c = crc_byte(c, s0[15:8]);
		c = crc_byte(c, s1[7:0]);
		c = crc_byte(c, s1[15:8]);
		c = crc_byte(c, k0[7:0]);
		c = crc_byte(c, k0[15:8]);
		c = crc_byte(c, k1[7:0]);
		return crc_byte(c, k1[15:8]);
	endfunction

	// permit check per command for the current guard level
	function automatic logic guard_allows(input logic [7:0] lvl,
			input logic [7:0] code);
		logic ok;
		ok = 1'b1;
		if (code == `CMD_WRITE_GUARD) begin
			ok = 1'b1;
		end else if (lvl == `GUARD_ALL) begin
			ok = 1'b0;
		end else if (lvl == `GUARD_CTRL) begin
			ok = (code == `CMD_OUTPUT_ON_OFF) ||
				(code == `CMD_CHANNEL_SELECT);
		end else if (lvl == `GUARD_VOUT) begin
			ok = (code == `CMD_OUTPUT_ON_OFF) ||
				(code == `CMD_CHANNEL_SELECT) ||
				(code == `CMD_VOLTAGE_SETPOINT);
		end
		return ok;
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		enSync0 <= enablePin;
		enSync1 <= enSync0;
		enSync2 <= enSync1;
		faultSync0 <= faultPresent;
		faultSync1 <= faultSync0;
		faultSync2 <= faultSync1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			enPin <= 2'b00;
			faultNow <= 2'b00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (enSync1[i] == enSync2[i]) begin
					enPin[i] <= enSync2[i];
				end
				if (faultSync1[i] == faultSync2[i]) begin
					faultNow[i] <= faultSync2[i];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	assign chan = channelSelect[0];
	assign nvBusy = (nvState != NV_IDLE);
	assign wrAny = cmdValid && cmdWrite;
	assign wrOk = wrAny && !nvBusy &&
		guard_allows(writeGuardLevel, cmdCode);
	assign clearReq = wrOk && (cmdCode == `CMD_CLEAR_FAULTS);
	assign wrChan = (channelSelect == `PAGE_BOTH) ? 2'b11 :
		(chan ? 2'b10 : 2'b01);

	// ----------------------------------------------------------------
	// single-copy registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			channelSelect <= `RST_CHANNEL_SELECT;
			writeGuardLevel <= `RST_WRITE_GUARD;
		end else if (wrOk) begin
			if (cmdCode == `CMD_CHANNEL_SELECT) begin
				channelSelect <= cmdData[7:0];
			end
			if (cmdCode == `CMD_WRITE_GUARD) begin
				writeGuardLevel <= cmdData[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// per-channel registers and restore
	// ----------------------------------------------------------------
	logic crcMatch;
	assign crcMatch = crc_image(nvOnOff[0], nvOnOff[1], nvSetpoint[0],
		nvSetpoint[1], nvScale[0], nvScale[1]) == nvCrc;

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < 2; i++) begin
				outputOnOff[i] <= `RST_OUTPUT_ON_OFF;
				voltageSetpoint[i] <= `RST_SETPOINT;
				scaleLoop[i] <= `RST_SCALE_LOOP;
			end
		end else if (nvState == NV_RESTORE && nvCount == 3'h0) begin
			if (crcMatch) begin
				for (int i = 0; i < 2; i++) begin
					outputOnOff[i] <= nvOnOff[i];
					voltageSetpoint[i] <= nvSetpoint[i];
					scaleLoop[i] <= nvScale[i];
				end
			end
		end else if (wrOk) begin
			for (int i = 0; i < 2; i++) begin
				if (wrChan[i]) begin
					if (cmdCode == `CMD_OUTPUT_ON_OFF) begin
						// only bit 7 is kept; others reserved
						outputOnOff[i] <= cmdData[7:0] & 8'h80;
					end
					if (cmdCode == `CMD_VOLTAGE_SETPOINT) begin
						voltageSetpoint[i] <= cmdData;
					end
					if (cmdCode == `CMD_SCALE_LOOP) begin
						scaleLoop[i] <= cmdData;
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// nonvolatile sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			nvState <= NV_IDLE;
			nvCount <= 3'h0;
		end else begin
			case (nvState)
				NV_IDLE: begin
					nvCount <= `NV_STEPS;
					if (wrOk && cmdCode == `CMD_STORE_ALL &&
							factoryBlank && !storeUsed) begin
						nvState <= NV_STORE;
					end else if (wrOk &&
							cmdCode == `CMD_RESTORE_ALL) begin
						nvState <= NV_RESTORE;
					end
				end
				NV_STORE, NV_RESTORE: begin
					if (nvCount == 3'h0) begin
						nvState <= NV_DONE;
					end else begin
						nvCount <= nvCount - 3'h1;
					end
				end
				NV_DONE: nvState <= NV_IDLE;
				default: nvState <= NV_IDLE;
			endcase
		end
	end

	// blank image: crc cell reads erased, so an early restore fails check
	always_ff @(posedge clk) begin
		if (rst) begin
			storeUsed <= 1'b0;
			nvCrc <= `NV_CRC_BLANK;
			for (int i = 0; i < 2; i++) begin
				nvOnOff[i] <= 8'h00;
				nvSetpoint[i] <= 16'h0000;
				nvScale[i] <= 16'h0000;
			end
		end else if (nvState == NV_STORE && nvCount == 3'h0) begin
			storeUsed <= 1'b1;
			for (int i = 0; i < 2; i++) begin
				nvOnOff[i] <= outputOnOff[i];
				nvSetpoint[i] <= voltageSetpoint[i];
				nvScale[i] <= scaleLoop[i];
			end
			nvCrc <= crc_image(outputOnOff[0], outputOnOff[1],
				voltageSetpoint[0], voltageSetpoint[1],
				scaleLoop[0], scaleLoop[1]);
		end
	end

	// ----------------------------------------------------------------
	// status and alert
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			statusCml <= 8'h00;
			crcFlag <= 1'b0;
			for (int i = 0; i < 2; i++) begin
				statusByte[i] <= 8'h00;
			end
		end else begin
			// clear; set wins so live faults come back
			for (int i = 0; i < 2; i++) begin
				statusByte[i][0] <= faultNow[i] ||
					(statusByte[i][0] && !clearReq);
				statusByte[i][`OFF_BIT] <= !channelEnable[i];
				statusByte[i][`CML_SUMMARY_BIT] <= 1'b0;
			end
			if (wrAny && !wrOk) begin
				statusCml <= statusCml | `CML_BAD_WRITE;
			end else if (clearReq) begin
				statusCml <= 8'h00;
			end
			if (nvState == NV_RESTORE && nvCount == 3'h0 && !crcMatch) begin
				crcFlag <= 1'b1;
			end else if (clearReq) begin
				crcFlag <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			alert_line <= 1'b0;
		end else begin
			alert_line <= statusByte[0][0] || statusByte[1][0] ||
				(statusCml != 8'h00) || crcFlag;
		end
	end

	// ----------------------------------------------------------------
	// outputs and read data
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			channelEnable <= 2'b00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				channelEnable[i] <= enPin[i] &&
					outputOnOff[i][`ON_BIT] && !latchedOff[i] &&
					!nvBusy;
			end
		end
	end

	// reads ignore guard level and busy state
	always_ff @(posedge clk) begin
		if (rst) begin
			rdData <= 16'h0000;
		end else if (cmdValid && !cmdWrite) begin
			if (cmdCode == `CMD_CHANNEL_SELECT) begin
				rdData <= {8'h00, channelSelect};
			end else if (cmdCode == `CMD_OUTPUT_ON_OFF) begin
				rdData <= {8'h00, outputOnOff[chan]};
			end else if (cmdCode == `CMD_WRITE_GUARD) begin
				rdData <= {8'h00, writeGuardLevel};
			end else if (cmdCode == `CMD_VOLTAGE_FORMAT) begin
				rdData <= {8'h00, `VOLTAGE_FORMAT_VAL};
			end else if (cmdCode == `CMD_VOLTAGE_SETPOINT) begin
				rdData <= voltageSetpoint[chan];
			end else if (cmdCode == `CMD_SCALE_LOOP) begin
				rdData <= scaleLoop[chan];
			end else if (cmdCode == `CMD_STATUS_BYTE) begin
				rdData <= {8'h00, statusByte[chan] |
					{6'h00, (statusCml != 8'h00) || crcFlag, 1'b0}};
			end else if (cmdCode == `CMD_STATUS_CML) begin
				rdData <= {8'h00, statusCml |
					{6'h00, crcFlag, 1'b0}};
			end else if (cmdCode == `CMD_CRC_FLAG) begin
				rdData <= {15'h0000, crcFlag};
			end else begin
				rdData <= 16'h0000;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_GUARD_BLOCKS: assert property (@(posedge clk) disable iff (rst)
		wrAny && writeGuardLevel == `GUARD_ALL &&
		cmdCode == `CMD_VOLTAGE_SETPOINT |=>
		$stable(voltageSetpoint[0]) && $stable(voltageSetpoint[1]))
		else $error("guarded write changed set-point");
	AST_BUSY_BLOCKS: assert property (@(posedge clk) disable iff (rst)
		wrAny && nvBusy && cmdCode == `CMD_CHANNEL_SELECT |=>
		$stable(channelSelect))
		else $error("write taken while busy");
	AST_BLOCK_FLAG: assert property (@(posedge clk) disable iff (rst)
		wrAny && !wrOk |=> statusCml[1])
		else $error("blocked write not flagged");
	AST_BROADCAST: assert property (@(posedge clk) disable iff (rst)
		wrOk && channelSelect == `PAGE_BOTH &&
		cmdCode == `CMD_VOLTAGE_SETPOINT && nvState == NV_IDLE |=>
		voltageSetpoint[0] == $past(cmdData) &&
		voltageSetpoint[1] == $past(cmdData))
		else $error("broadcast missed a channel");
	AST_OFF_BUSY: assert property (@(posedge clk) disable iff (rst)
		nvBusy |=> channelEnable == 2'b00)
		else $error("output on during nonvolatile work");
	AST_PIN_WINS: assert property (@(posedge clk) disable iff (rst)
		!enPin[0] |=> !channelEnable[0])
		else $error("enable pin overridden");
	AST_ONE_STORE: assert property (@(posedge clk) disable iff (rst)
		storeUsed && nvState == NV_IDLE |=> nvState != NV_STORE)
		else $error("second store started");
	AST_REFAULT: assert property (@(posedge clk) disable iff (rst)
		clearReq && faultNow[0] |=> statusByte[0][0])
		else $error("live fault lost on clear");
	AST_FORMAT: assert property (@(posedge clk) disable iff (rst)
		cmdValid && !cmdWrite && cmdCode == `CMD_VOLTAGE_FORMAT |=>
		rdData == 16'h0016)
		else $error("format read wrong");
	AST_NV_LEN: assert property (@(posedge clk) disable iff (rst)
		$rose(nvBusy) |-> nvBusy [*6] ##1 !nvBusy)
		else $error("nonvolatile length wrong");
	COV_STORE: cover property (@(posedge clk) nvState == NV_STORE);
	COV_RESTORE_BAD: cover property (@(posedge clk) $rose(crcFlag));
	COV_BROADCAST: cover property (@(posedge clk)
		wrOk && channelSelect == `PAGE_BOTH);
	COV_CLEAR: cover property (@(posedge clk) clearReq && alert_line);
endmodule

// File: test/pmbus_dual_channel_command_core_tb.sv
`timescale 1ns/1ps
module pmbus_dual_channel_command_core_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cmdValid, cmdWrite, factoryBlank, alert_line, nvBusy;
	logic [7:0] cmdCode;
	logic [15:0] cmdData, rdData, v;
	logic [1:0] enablePin, faultPresent, latchedOff, channelEnable;
	int failCount = 0;
	int comparisons = 0;
	int cycles = 0;
	int mPage = 0, mGuard = 0, mCml = 0, stored = 0;
	int mSet[2], mOp[2], nvSet[2], nvOp[2];
	int mScale[2], nvScale[2];
	int ops[5] = '{'h80, 'h40, 'hC0, 'h00, 'h80};
	int lv[4] = '{'h80, 'h40, 'h20, 'h00};
	always #4 clk = ~clk;
	pmbus_host_model host (.clk(clk), .cmdValid(cmdValid),
		.cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdData(cmdData));
	pmbus_dual_channel_command_core dut (.clk(clk), .rst(rst),
		.cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
		.cmdData(cmdData), .rdData(rdData), .factoryBlank(factoryBlank),
		.enablePin(enablePin), .faultPresent(faultPresent),
		.latchedOff(latchedOff), .channelEnable(channelEnable),
		.alert_line(alert_line), .nvBusy(nvBusy));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failCount++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen,
				exp);
		end
	endtask
	task automatic testDone;
		$display("%0d comparisons, %0d mismatches", comparisons, failCount);
		if (failCount == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failCount++;
			testDone;
		end
	end
	// --------------------------------
	// reference model
	// --------------------------------
	function automatic bit sel(input int i);
		return mPage == 'hFF || (mPage & 1) == i;
	endfunction
	function automatic bit allowed(input int c);
		if (mGuard == 'h80) return c == 'h10;
		if (mGuard == 'h40) return c inside {'h10, 'h00, 'h01};
		if (mGuard == 'h20) return c inside {'h10, 'h00, 'h01, 'h21};
		return 1'b1;
	endfunction
	task automatic wr(input int c, input int d);
		bit ok;
		ok = allowed(c) && nvBusy === 1'b0;
		host.send(1'b1, 8'(c), 16'(d));
		if (!ok) mCml = 1;
		else case (c)
			'h00: mPage = d & 'hFF;
			'h01: foreach (mOp[i]) if (sel(i)) mOp[i] = d & 'h80;
			'h21: foreach (mSet[i]) if (sel(i)) mSet[i] = d & 'hFFFF;
			'h29: foreach (mScale[i]) if (sel(i)) mScale[i] = d & 'hFFFF;
			'h10: mGuard = d & 'hFF;
			'h03: mCml = 0;
			'h15: if (factoryBlank && !stored) begin
				nvSet = mSet;
				nvOp = mOp;
				nvScale = mScale;
				stored = 1;
			end
			'h16: if (stored) begin
				mSet = nvSet;
				mOp = nvOp;
				mScale = nvScale;
			end else mCml = 1;
			default: ;
		endcase
	endtask
	task automatic rdChk(input int c);
		int e;
		host.send(1'b0, 8'(c), 16'h0000);
		v = (c == 'h7E) ? (rdData & 16'h0002) : rdData;
		case (c)
			'h00: e = mPage;
			'h01: e = mOp[mPage & 1];
			'h10: e = mGuard;
			'h20: e = 'h16;
			'h21: e = mSet[mPage & 1];
			'h29: e = mScale[mPage & 1];
			'h7E: e = mCml * 2;
			default: e = 0;
		endcase
		check(v, 16'(e));
	endtask
	task automatic enChk(input int waitCycles);
		logic [1:0] e;
		repeat (waitCycles) @(negedge clk);
		foreach (mOp[i]) e[i] = mOp[i] != 0 && enablePin[i] && !latchedOff[i];
		check(16'(channelEnable), 16'(e));
	endtask
	task automatic waitIdle;
		for (int i = 0; i < 20 && nvBusy !== 1'b0; i++) @(negedge clk);
		check(16'(nvBusy), 16'h0000);
	endtask
	// --------------------------------
	// tests
	// --------------------------------
	initial begin
		factoryBlank = 1'b0;
		enablePin = 2'b00;
		faultPresent = 2'b00;
		latchedOff = 2'b00;
		mSet = '{'h1400, 'h1400};
		mScale = '{'hB052, 'hB052};
		mOp = '{0, 0};
		void'($urandom(7918));
		repeat (12) @(negedge clk);
		rst = 1'b0;
		foreach (lv[i]) rdChk(i < 2 ? i : 'h10);
		rdChk('h20);
		rdChk('h21);
		rdChk('h29);
		rdChk('h05);
		check(16'(alert_line), 16'h0000);
		$display("reset test done");
		for (int p = 0; p < 3; p++) begin
			wr(8'h00, p == 2 ? 'hFF : p);
			wr(8'h21, $urandom);
			wr(8'h29, $urandom);
			rdChk(8'h00);
		end
		for (int p = 0; p < 2; p++) begin
			wr(8'h00, p);
			rdChk(8'h21);
			rdChk(8'h29);
			rdChk(8'h10);
		end
		$display("channel select test done");
		wr(8'h00, 8'hFF);
		enablePin = 2'b11;
		foreach (ops[i]) begin
			wr(8'h01, ops[i]);
			enChk(6);
			rdChk(8'h01);
		end
		enablePin = 2'b01;
		enChk(8);
		latchedOff = 2'b01;
		enChk(2);
		wr(8'h03, 0);
		enChk(4);
		{latchedOff, enablePin} = {2'b00, 2'b11};
		$display("on off test done");
		foreach (lv[i]) begin
			wr(8'h10, lv[i]);
			wr(8'h21, $urandom);
			wr(8'h00, i & 1);
			wr(8'h01, 8'h80);
			rdChk(8'h21);
			rdChk(8'h00);
			rdChk(8'h7E);
			wr(8'h03, 0);
			rdChk(8'h7E);
		end
		$display("write guard test done");
		faultPresent = 2'b01;
		repeat (8) @(negedge clk);
		check(16'(alert_line), 16'h0001);
		wr(8'h00, 0);
		host.send(1'b0, 8'h78, 16'h0000);
		check(rdData, 16'h0001);
		wr(8'h03, 0);
		repeat (2) @(negedge clk);
		check(16'(alert_line), 16'h0001);
		faultPresent = 2'b00;
		repeat (8) @(negedge clk);
		wr(8'h03, 0);
		repeat (2) @(negedge clk);
		check(16'(alert_line), 16'h0000);
		host.send(1'b0, 8'h78, 16'h0000);
		check(rdData, 16'h0000);
		$display("fault test done");
		wr(8'h15, 0);
		waitIdle;
		wr(8'h16, 0);
		waitIdle;
		host.send(1'b0, 8'hD5, 16'h0000);
		check(rdData & 16'h0001, 16'h0001);
		rdChk(8'h7E);
		wr(8'h03, 0);
		factoryBlank = 1'b1;
		wr(8'h15, 0);
		wr(8'h21, $urandom);
		wr(8'h00, 0);
		rdChk(8'h21);
		check(16'(channelEnable), 16'h0000);
		waitIdle;
		enChk(8);
		wr(8'h21, $urandom);
		wr(8'h01, 8'h00);
		wr(8'h15, 0);
		waitIdle;
		wr(8'h16, 0);
		waitIdle;
		rdChk(8'h21);
		rdChk(8'h01);
		enChk(8);
		$display("nonvolatile test done");
		testDone;
	end
endmodule

// File: test/pmbus_host_model.sv
`timescale 1ns/1ps
module pmbus_host_model (
	input wire logic clk,
	output logic cmdValid,
	output logic cmdWrite,
	output logic [7:0] cmdCode,
	output logic [15:0] cmdData
);
	initial begin
		cmdValid = 1'b0;
		cmdWrite = 1'b0;
		cmdCode = 8'h00;
		cmdData = 16'h0000;
	end
	// one-cycle command pulse; idle fields are scrambled so that stale
	// values can never pass for a live command
	task automatic send(input logic w, input logic [7:0] c,
			input logic [15:0] d);
		@(negedge clk);
		cmdValid = 1'b1;
		cmdWrite = w;
		cmdCode = c;
		cmdData = d;
		@(negedge clk);
		cmdValid = 1'b0;
		cmdCode = ~c;
		cmdData = ~d;
	endtask
endmodule
